//--- pkg/swa_pkg.sv
// shared widths, reset values, states and carriers for the write and address port
package swa_pkg;

    localparam int SWA_DATA_W = 36;
    localparam int SWA_LANES = 4;
    localparam int SWA_LANE_W = 9;
    localparam int SWA_ADDR_W = 19;
    localparam int SWA_BURST = 4;
    localparam int SWA_BEAT_W = 2;
    localparam int SWA_WORD_ADDR_W = SWA_ADDR_W + SWA_BEAT_W;

    // address slot that the next K edge belongs to
    localparam logic SWA_SLOT_READ = 1'b0;
    localparam logic SWA_SLOT_WRITE = 1'b1;
    localparam logic SWA_SLOT_RST = SWA_SLOT_READ;

    localparam logic [SWA_BEAT_W-1:0] SWA_BEAT_RST = 2'h0;
    localparam logic [SWA_ADDR_W-1:0] SWA_ADDR_RST = 19'h00000;
    localparam logic [SWA_DATA_W-1:0] SWA_DATA_RST = 36'h000000000;
    localparam logic [SWA_LANES-1:0] SWA_LANE_OFF = 4'h0;

    // gray codes along idle, beat 0..3
    typedef enum logic [2:0] {
        SWA_WR_IDLE = 3'h0,
        SWA_WR_B0 = 3'h1,
        SWA_WR_B1 = 3'h3,
        SWA_WR_B2 = 3'h2,
        SWA_WR_B3 = 3'h6
    } swa_wr_state_t;

    // one captured write beat headed for the array
    typedef struct packed {
        logic valid;
        logic [SWA_WORD_ADDR_W-1:0] word_addr;
        logic [SWA_LANES-1:0] lane_en;
        logic [SWA_DATA_W-1:0] data;
    } swa_beat_t;

    localparam swa_beat_t SWA_BEAT_IDLE = '{
        valid: 1'b0,
        word_addr: 21'h000000,
        lane_en: 4'h0,
        data: 36'h000000000
    };

endpackage : swa_pkg

//--- rtl/swa_lane_mem.sv
// byte-lane maskable storage array with registered inspection read
`timescale 1ns/1ps

module swa_lane_mem #(
    parameter int ADDR_W = 21,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic sys_clk_in,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [LANES-1:0] lane_en_in,
    input wire logic [LANES*LANE_W-1:0] wr_data_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [LANES*LANE_W-1:0] rd_data_out
);

    logic [LANES*LANE_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    ////////////////////////////////////////////////////////////////////////
    // each lane written on its own enable; disabled lanes keep old contents
    // one process for all lanes: a word indexed at run time has one writer only
    always_ff @(posedge sys_clk_in) begin
        for (int l = 0; l < LANES; l++) begin
            if (wr_en_in && lane_en_in[l]) begin
                mem_q[wr_addr_in][l*LANE_W +: LANE_W] <= wr_data_in[l*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        rd_data_out <= mem_q[rd_addr_in];
    end

endmodule : swa_lane_mem

//--- rtl/swa_write_port.sv
// write data capture, write select, byte masking and shared address sampling
`timescale 1ns/1ps
//
// Contract
// - write data captured on both K and K# rising edges during a write
// - write select active low, sampled on K edges; low starts a write
// - write select high deselects the port; data inputs are ignored
// - four active-low byte selects sampled on both edges during writes
// - select n governs nine-bit lane n of the 36-bit data word
// - byte selects sampled on the very edge that samples their data beat
// - byte select high drops that byte; stored lane stays unchanged
// - shared address bus sampled on K edges for reads and writes
// - array is four 512K by 36 words behind a 19-bit address
// - address ignored when the port that would use it is deselected
// - read and write addresses latched on alternating K edges
// - each address names a burst of four sequential 36-bit words

module swa_write_port
    import swa_pkg::*;
#(
    parameter int ADDR_W = SWA_ADDR_W,
    parameter int BURST = SWA_BURST
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // high: this cycle is a K rising edge; low: a K# rising edge
    input wire logic k_edge_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic write_port_select_n_in,
    input wire logic read_port_select_n_in,
    input wire logic [SWA_LANES-1:0] byte_lane_write_select_n_in,
    input wire logic [SWA_DATA_W-1:0] write_data_in,
    input wire logic [ADDR_W+SWA_BEAT_W-1:0] inspect_addr_in,
    output logic read_req_out,
    output logic [ADDR_W-1:0] read_addr_out,
    output logic write_accept_out,
    output logic [ADDR_W-1:0] write_addr_out,
    output logic write_busy_out,
    output logic [SWA_DATA_W-1:0] inspect_data_out
);

    localparam int WORD_W = ADDR_W + SWA_BEAT_W;

    logic slot_q;
    swa_wr_state_t wr_state_q;
    swa_wr_state_t wr_state_d;
    logic [SWA_BEAT_W-1:0] beat_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic beat_valid_q;
    logic [SWA_WORD_ADDR_W-1:0] beat_addr_q;
    logic [SWA_LANES-1:0] beat_lanes_q;
    logic [SWA_DATA_W-1:0] beat_data_q;
    logic [SWA_LANES-1:0] lane_en_d;
    swa_beat_t beat_bus;
    logic write_slot_edge;
    logic read_slot_edge;
    logic accept;
    logic in_burst;

    assign write_slot_edge = k_edge_in && (slot_q == SWA_SLOT_WRITE);
    assign read_slot_edge = k_edge_in && (slot_q == SWA_SLOT_READ);
    assign accept = write_slot_edge && !write_port_select_n_in;
    assign in_burst = (wr_state_q != SWA_WR_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // address slot alternation on K edges
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slot_q <= SWA_SLOT_RST;
        end else if (k_edge_in) begin
            slot_q <= ~slot_q;
        end
    end

    // read request pulses only when the read port is selected on its slot
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_req_out <= 1'b0;
        end else begin
            read_req_out <= read_slot_edge && !read_port_select_n_in;
        end
    end

    // deselected read slot leaves the last read address standing
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_addr_out <= ADDR_W'(SWA_ADDR_RST);
        end else if (read_slot_edge && !read_port_select_n_in) begin
            read_addr_out <= address_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write burst sequencing
    always_comb begin
        wr_state_d = wr_state_q;
        unique case (wr_state_q)
            SWA_WR_IDLE: begin
                if (accept) begin
                    wr_state_d = SWA_WR_B0;
                end
            end
            SWA_WR_B0: begin
                wr_state_d = SWA_WR_B1;
            end
            SWA_WR_B1: begin
                wr_state_d = SWA_WR_B2;
            end
            SWA_WR_B2: begin
                wr_state_d = SWA_WR_B3;
            end
            SWA_WR_B3: begin
                // last beat lands on the next write slot, so bursts chain
                wr_state_d = accept ? SWA_WR_B0 : SWA_WR_IDLE;
            end
            default: begin
                wr_state_d = SWA_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_state_q <= SWA_WR_IDLE;
        end else begin
            wr_state_q <= wr_state_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_accept_out <= 1'b0;
        end else begin
            write_accept_out <= accept;
        end
    end

    // burst address; a chained accept on beat 3 updates it after that beat is taken
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_addr_q <= ADDR_W'(SWA_ADDR_RST);
        end else if (accept) begin
            wr_addr_q <= address_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_addr_out <= ADDR_W'(SWA_ADDR_RST);
        end else if (accept) begin
            write_addr_out <= address_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_q <= SWA_BEAT_RST;
        end else if (!in_burst) begin
            beat_q <= SWA_BEAT_RST;
        end else begin
            beat_q <= beat_q + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_busy_out <= 1'b0;
        end else begin
            write_busy_out <= (wr_state_d != SWA_WR_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // beat capture: data and its byte selects taken on one and the same edge
    always_comb begin
        lane_en_d = SWA_LANE_OFF;
        for (int l = 0; l < SWA_LANES; l++) begin
            lane_en_d[l] = !byte_lane_write_select_n_in[l];
        end
    end

    // deselected port: data and selects on the pins are not looked at
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_valid_q <= SWA_BEAT_IDLE.valid;
        end else begin
            beat_valid_q <= in_burst;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_addr_q <= SWA_BEAT_IDLE.word_addr;
        end else if (in_burst) begin
            beat_addr_q <= SWA_WORD_ADDR_W'({wr_addr_q, beat_q});
        end
    end

    // lanes cleared outside bursts so a stray write enable can never store
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_lanes_q <= SWA_BEAT_IDLE.lane_en;
        end else if (in_burst) begin
            beat_lanes_q <= lane_en_d;
        end else begin
            beat_lanes_q <= SWA_LANE_OFF;
        end
    end

    // data register only loads in a burst: idle pins cost no toggling
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beat_data_q <= SWA_BEAT_IDLE.data;
        end else if (in_burst) begin
            beat_data_q <= write_data_in;
        end
    end

    assign beat_bus = '{
        valid: beat_valid_q,
        word_addr: beat_addr_q,
        lane_en: beat_lanes_q,
        data: beat_data_q
    };

    swa_lane_mem #(
        .ADDR_W(WORD_W),
        .LANES(SWA_LANES),
        .LANE_W(SWA_LANE_W)
    ) u_mem (
        .sys_clk_in(sys_clk_in),
        .wr_en_in(beat_bus.valid),
        .wr_addr_in(beat_bus.word_addr[WORD_W-1:0]),
        .lane_en_in(beat_bus.lane_en),
        .wr_data_in(beat_bus.data),
        .rd_addr_in(inspect_addr_in),
        .rd_data_out(inspect_data_out)
    );

endmodule : swa_write_port

//--- sim/swa_write_port_asserts.sv
// checker for the write and address port
`timescale 1ns/1ps
module swa_write_port_asserts
    import swa_pkg::*;
#(
    parameter int ADDR_W = SWA_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic k_edge_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic write_port_select_n_in,
    input wire logic read_port_select_n_in,
    input wire logic read_req_out,
    input wire logic [ADDR_W-1:0] read_addr_out,
    input wire logic write_accept_out,
    input wire logic [ADDR_W-1:0] write_addr_out,
    input wire logic write_busy_out
);
    logic slot_q;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) slot_q <= SWA_SLOT_RST;
        else if (k_edge_in) slot_q <= ~slot_q;
    end
    wire wr_take = k_edge_in && slot_q && !write_port_select_n_in;
    wire rd_take = k_edge_in && !slot_q && !read_port_select_n_in;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_wacc; wr_take |=> write_accept_out && write_addr_out == $past(address_in);
    endproperty
    a_wacc: assert property (p_wacc) else $error("write not taken");
    property p_wnone; !wr_take |=> !write_accept_out; endproperty
    a_wnone: assert property (p_wnone) else $error("stray write accept");
    property p_racc; rd_take |=> read_req_out && read_addr_out == $past(address_in); endproperty
    a_racc: assert property (p_racc) else $error("read not taken");
    property p_rnone; !rd_take |=> !read_req_out; endproperty
    a_rnone: assert property (p_rnone) else $error("stray read request");
    property p_whold; !write_accept_out |-> $stable(write_addr_out); endproperty
    a_whold: assert property (p_whold) else $error("write address moved");
    property p_busy; write_accept_out |-> write_busy_out [*4]; endproperty
    a_busy: assert property (p_busy) else $error("burst too short");
    property p_brise; $rose(write_busy_out) |-> write_accept_out; endproperty
    a_brise: assert property (p_brise) else $error("busy without accept");
    property p_bend; write_accept_out ##4 !write_accept_out |-> !write_busy_out; endproperty
    a_bend: assert property (p_bend) else $error("burst too long");
    c_wr: cover property (write_accept_out);
    c_rd: cover property (read_req_out);
    c_both: cover property (write_busy_out && read_req_out);
endmodule : swa_write_port_asserts

bind swa_write_port swa_write_port_asserts #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_in, .rst_n_in,
    .k_edge_in, .address_in, .write_port_select_n_in, .read_port_select_n_in, .read_req_out,
    .read_addr_out, .write_accept_out, .write_addr_out, .write_busy_out);

//--- sim/swa_ctrl_model.sv
// memory controller model: K phase, selects, address and write beats
`timescale 1ns/1ps
module swa_ctrl_model #(
    parameter int AW = 6
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    output logic k_edge_out,
    output logic [AW-1:0] addr_out = '1,
    output logic write_port_select_n_out = 1'b1,
    output logic read_port_select_n_out = 1'b1,
    output logic [3:0] byte_lane_write_select_n_out = 4'hF,
    output logic [35:0] data_out = 36'h0
);
    logic [1:0] ph_q = 2'h0;
    // phase moves on the falling edge so k never changes at sampling
    always @(negedge sys_clk_in) ph_q <= rst_n_in ? ph_q + 2'h1 : 2'h0;
    assign k_edge_out = ~ph_q[0];
    task automatic step();
        @(negedge sys_clk_in);
        #1;
    endtask : step
    task automatic wr(input logic [AW-1:0] a, input logic [3:0][35:0] d,
                      input logic [3:0][3:0] bw);
        // always step first: a call made on a falling edge sees the old phase
        do begin
            step();
        end while (ph_q != 2'h2);
        addr_out = a;
        write_port_select_n_out = 1'b0;
        for (int i = 0; i < 4; i++) begin
            step();
            write_port_select_n_out = 1'b1;
            addr_out = ~a;
            data_out = d[i];
            byte_lane_write_select_n_out = bw[i];
        end
        step();
        // released data flips so stale beats cannot pass
        data_out = ~d[3];
        byte_lane_write_select_n_out = 4'h0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        do begin
            step();
        end while (ph_q != 2'h0);
        addr_out = a;
        read_port_select_n_out = 1'b0;
        write_port_select_n_out = 1'b0;
        step();
        addr_out = ~a;
        read_port_select_n_out = 1'b1;
        write_port_select_n_out = 1'b1;
    endtask : rd
endmodule : swa_ctrl_model

//--- sim/tb_swa_write_port.sv
// self-checking bench for the write and address port
`timescale 1ns/1ps
module tb_swa_write_port;
    localparam int AW = 6;
    typedef struct packed {logic [AW-1:0] a; logic [35:0] d; logic [15:0] bw;} swa_row_t;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic k, wps_n, rps_n, rreq, wacc, busy;
    logic [AW-1:0] addr, raddr, waddr;
    logic [3:0] bw_n;
    logic [35:0] wdata, idata;
    logic [AW+1:0] insp = '0;
    logic [35:0] shadow [0:255];
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    swa_row_t rows [5] = '{'{6'h05, 36'h123456789, 16'h0000},
        '{6'h05, 36'hABCDEF012, 16'h8421}, '{6'h3F, 36'hFFFFFFFFF, 16'h0000},
        '{6'h3F, 36'h0F0F0F0F0, 16'hF0E7}, '{6'h00, 36'h555555555, 16'h0000}};
    initial forever #10 sys_clk_in = ~sys_clk_in;
    swa_ctrl_model #(.AW(AW)) u_ctrl (.sys_clk_in, .rst_n_in, .k_edge_out(k), .addr_out(addr),
        .write_port_select_n_out(wps_n), .read_port_select_n_out(rps_n),
        .byte_lane_write_select_n_out(bw_n), .data_out(wdata));
    swa_write_port #(.ADDR_W(AW)) u_dut (.sys_clk_in, .rst_n_in, .k_edge_in(k),
        .address_in(addr), .write_port_select_n_in(wps_n), .read_port_select_n_in(rps_n),
        .byte_lane_write_select_n_in(bw_n), .write_data_in(wdata), .inspect_addr_in(insp),
        .read_req_out(rreq), .read_addr_out(raddr), .write_accept_out(wacc),
        .write_addr_out(waddr), .write_busy_out(busy), .inspect_data_out(idata));
    task automatic end_sim();
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkw(input logic [AW+1:0] wa);
        @(negedge sys_clk_in);
        insp = wa;
        @(negedge sys_clk_in);
        chk(idata, shadow[wa]);
    endtask : chkw
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            $display("CHECK FAILED %0t timeout", $time);
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0][35:0] dv;
        repeat (16) @(negedge sys_clk_in);
        chk({rreq, wacc, busy, raddr, waddr}, 36'h0);
        rst_n_in <= 1'b1;
        foreach (rows[r]) begin
            for (int i = 0; i < 4; i++) begin
                dv[i] = rows[r].d + 36'(i);
                for (int l = 0; l < 4; l++)
                    if (!rows[r].bw[i*4+l]) shadow[{rows[r].a, 2'(i)}][l*9+:9] = dv[i][l*9+:9];
            end
            u_ctrl.wr(rows[r].a, dv, rows[r].bw);
            chk(waddr, rows[r].a);
            for (int i = 0; i < 4; i++) chkw({rows[r].a, 2'(i)});
        end
        u_ctrl.rd(6'h2A);
        chk({rreq, wacc, raddr}, {2'h2, 6'h2A});
        chk(waddr, 6'h00);
        chkw({6'h05, 2'h1});
        rst_n_in <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk({rreq, wacc, busy, raddr, waddr}, 36'h0);
        rst_n_in <= 1'b1;
        u_ctrl.wr(6'h11, '0, '1);
        chk(waddr, 6'h11);
        chkw({6'h3F, 2'h2});
        end_sim();
    end
endmodule : tb_swa_write_port
